// File: shared/irq_ctl_pkg.sv
// package: codes, bit positions and reset values for the interrupt control block
`default_nettype none
package irq_ctl_pkg;
  localparam int MASK_W = 12;                          // mask and code field width
  localparam logic [5:0] OP_MAJOR  = 6'h3F;            // major code 77 octal
  localparam logic [2:0] SUB_CTL5  = 3'h5;             // sub-division 5
  localparam logic [2:0] SUB_CTL7  = 3'h7;             // sub-division 7
  localparam logic [2:0] SUB_SENSE = 3'h4;             // sense interrupt
  localparam logic [2:0] SUB_CPYX  = 3'h2;             // copy external status
  localparam logic [2:0] SUB_CPYI  = 3'h3;             // copy internal status
  // second sub-code under 5
  localparam logic [2:0] F5_CLEAR  = 3'h0;
  localparam logic [2:0] F5_MSET   = 3'h2;
  localparam logic [2:0] F5_MCLR   = 3'h3;
  localparam logic [2:0] F5_PEER   = 3'h7;
  // second sub-code under 7
  localparam logic [2:0] F7_FLOAT  = 3'h1;
  localparam logic [2:0] F7_DEC    = 3'h2;
  localparam logic [2:0] F7_OFF    = 3'h3;
  localparam logic [2:0] F7_ON     = 3'h4;
  // condition positions
  localparam int CH_LO      = 0;
  localparam int CH_HI      = 7;
  localparam int BIT_CLOCK  = 8;
  localparam int BIT_EXPBCD = 9;
  localparam int BIT_ARITH  = 10;
  localparam int BIT_BLOCK  = 11;
  localparam logic [11:0] MASK_RST = 12'h000;          // mask value after reset
  localparam int ACC_HI_LSB = 12;                      // mask lands in bits 23..12
  // decoded instruction word fields
  typedef struct packed {
    logic [5:0]  major;
    logic [2:0]  sub;
    logic [2:0]  fn;
    logic [11:0] code;
  } instr_t;
  // state of the global enable
  typedef enum logic [2:0] {
    GE_OFF  = 3'b001,
    GE_HOLD = 3'b010,
    GE_ON   = 3'b100
  } gen_state_t;
endpackage
`default_nettype wire

// File: rtl/irq_ctl.sv
// interrupt mask, fault flags, global enable and peer interrupt logic
`default_nettype none
module irq_ctl (
  input  wire logic                 MCLK,         // processor clock
  input  wire logic                 RSTN,         // async reset, active low
  input  wire irq_ctl_pkg::instr_t  INSTR,        // instruction being executed
  input  wire logic                 INSTR_VALID,  // one-cycle execute strobe
  input  wire logic [7:0]           CH_INT_INT,   // internal channel events (pulses)
  input  wire logic [7:0]           CH_INT_EXT,   // external channel lines (levels)
  input  wire logic                 CLOCK_EV,     // real-time clock event pulse
  input  wire logic                 ARITH_EV,     // arithmetic/divide fault pulse
  input  wire logic                 EXP_EV,       // exponent overflow pulse
  input  wire logic                 BLOCK_EV,     // block op completion pulse
  input  wire logic                 PEER_ACK,     // peer recognized interrupt
  output logic [11:0]               MASK,         // interrupt enable mask
  output logic [11:0]               COND,         // active condition bits
  output logic [23:0]               ACC_STATUS,   // status copy, mask in upper bits
  output logic                      ACC_LOAD,     // status copy strobe
  output logic                      SENSE_HIT,    // sense matched (no skip)
  output logic                      IRQ_TAKE,     // interrupt may be taken
  output logic                      GLOBAL_EN,    // global interrupt enable
  output logic                      PEER_IRQ      // interrupt to peer processor
);
  // ==========================================================
  // decode
  logic        op5, op7, op_sense, op_cpy;
  logic        do_clear, do_mset, do_mclr, do_peer, do_float, do_dec, do_off, do_on;
  logic [11:0] code;
  always_comb begin
    code     = INSTR.code;
    op5      = INSTR_VALID && INSTR.major == irq_ctl_pkg::OP_MAJOR
               && INSTR.sub == irq_ctl_pkg::SUB_CTL5;
    op7      = INSTR_VALID && INSTR.major == irq_ctl_pkg::OP_MAJOR
               && INSTR.sub == irq_ctl_pkg::SUB_CTL7;
    op_sense = INSTR_VALID && INSTR.major == irq_ctl_pkg::OP_MAJOR
               && INSTR.sub == irq_ctl_pkg::SUB_SENSE;
    op_cpy   = INSTR_VALID && INSTR.major == irq_ctl_pkg::OP_MAJOR
               && (INSTR.sub == irq_ctl_pkg::SUB_CPYX || INSTR.sub == irq_ctl_pkg::SUB_CPYI);
    do_clear = op5 && INSTR.fn == irq_ctl_pkg::F5_CLEAR;
    do_mset  = op5 && INSTR.fn == irq_ctl_pkg::F5_MSET;
    do_mclr  = op5 && INSTR.fn == irq_ctl_pkg::F5_MCLR;
    do_peer  = op5 && INSTR.fn == irq_ctl_pkg::F5_PEER;
    do_float = op7 && INSTR.fn == irq_ctl_pkg::F7_FLOAT;
    do_dec   = op7 && INSTR.fn == irq_ctl_pkg::F7_DEC;
    do_off   = op7 && INSTR.fn == irq_ctl_pkg::F7_OFF;
    do_on    = op7 && INSTR.fn == irq_ctl_pkg::F7_ON;
  end

  // at most one control operation per instruction
  decode_one_a: assert property (@(posedge MCLK) disable iff (!RSTN)
    $onehot0({do_clear, do_mset, do_mclr, do_peer, do_float, do_dec, do_off, do_on}))
    else $error("two operations decoded at once");

  // ==========================================================
  // mask register
  logic [11:0] mask_q, mask_d;
  always_comb begin
    mask_d = mask_q;
    if (do_mset) begin
      mask_d = mask_q | code;
    end else if (do_mclr) begin
      mask_d = mask_q & ~code;
    end
  end
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      mask_q <= irq_ctl_pkg::MASK_RST;
    end else begin
      mask_q <= mask_d;
    end
  end

  // mask bits move only under set and clear codes, and only where selected
  mask_set_a: assert property (@(posedge MCLK) disable iff (!RSTN)
    do_mset |=> (mask_q & $past(code)) == $past(code))
    else $error("mask set failed");
  mask_clr_a: assert property (@(posedge MCLK) disable iff (!RSTN)
    do_mclr |=> (mask_q & $past(code)) == 12'h000)
    else $error("mask clear failed");
  mask_others_a: assert property (@(posedge MCLK) disable iff (!RSTN)
    do_mset || do_mclr |=> (mask_q & ~$past(code)) == ($past(mask_q) & ~$past(code)))
    else $error("mask operation touched other bits");
  mask_keep_a: assert property (@(posedge MCLK) disable iff (!RSTN)
    !do_mset && !do_mclr |=> $stable(mask_q))
    else $error("mask changed without an operation");

  // ==========================================================
  // internal condition flip-flops, set wins over clear
  logic [11:0] intl_q, intl_d, set_v, clr_v;
  logic        flt_q, flt_d, bcd_q, bcd_d;
  logic [11:0] sense_clr;
  always_comb begin
    set_v = '0;
    set_v[irq_ctl_pkg::CH_HI:irq_ctl_pkg::CH_LO] = CH_INT_INT;
    set_v[irq_ctl_pkg::BIT_CLOCK]  = CLOCK_EV;
    set_v[irq_ctl_pkg::BIT_EXPBCD] = EXP_EV;
    set_v[irq_ctl_pkg::BIT_ARITH]  = ARITH_EV;
    set_v[irq_ctl_pkg::BIT_BLOCK]  = BLOCK_EV;
    sense_clr = '0;
    if (op_sense) begin
      sense_clr[11:8] = code[11:8] & intl_q[11:8];
    end
    clr_v = (do_clear ? code : 12'h000) | sense_clr;
    intl_d = (intl_q & ~clr_v) | set_v;
    flt_d = do_float | (flt_q & ~clr_v[irq_ctl_pkg::BIT_EXPBCD]);
    bcd_d = do_dec | (bcd_q & ~clr_v[irq_ctl_pkg::BIT_EXPBCD]);
  end
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      intl_q <= 12'h000;
      flt_q  <= 1'b0;
      bcd_q  <= 1'b0;
    end else begin
      intl_q <= intl_d;
      flt_q  <= flt_d;
      bcd_q  <= bcd_d;
    end
  end

  // events latch, selected faults clear, sensed bits 11..8 of the latch drop, channel bits stay
  // an event in the cycle of its clear must survive, hence the masked past
  event_latch_a: assert property (@(posedge MCLK) disable iff (!RSTN)
    set_v != 12'h000 |=> (intl_q & $past(set_v)) == $past(set_v))
    else $error("event not latched");
  clock_bit_a: assert property (@(posedge MCLK) disable iff (!RSTN)
    CLOCK_EV |=> COND[irq_ctl_pkg::BIT_CLOCK])
    else $error("clock event not on bit 8");
  block_bit_a: assert property (@(posedge MCLK) disable iff (!RSTN)
    BLOCK_EV |=> COND[irq_ctl_pkg::BIT_BLOCK])
    else $error("block event not on bit 11");
  fault_clear_a: assert property (@(posedge MCLK) disable iff (!RSTN)
    do_clear |=> (intl_q & $past(code) & ~$past(set_v)) == 12'h000)
    else $error("selected fault not cleared");
  flag_clear_a: assert property (@(posedge MCLK) disable iff (!RSTN)
    do_clear && code[irq_ctl_pkg::BIT_EXPBCD] |=> !flt_q && !bcd_q)
    else $error("fault flip-flop not cleared");
  sense_clear_a: assert property (@(posedge MCLK) disable iff (!RSTN)
    op_sense |=> (intl_q[11:8] & $past(code[11:8]) & ~$past(set_v[11:8])) == 4'h0)
    else $error("sensed condition not cleared");
  sense_keep_a: assert property (@(posedge MCLK) disable iff (!RSTN)
    op_sense |=> (intl_q[7:0] & $past(intl_q[7:0])) == $past(intl_q[7:0]))
    else $error("sense cleared a channel bit");
  float_path_a: assert property (@(posedge MCLK) disable iff (!RSTN)
    do_float |=> COND[irq_ctl_pkg::BIT_EXPBCD])
    else $error("float fault not on bit 9");
  dec_path_a: assert property (@(posedge MCLK) disable iff (!RSTN)
    do_dec |=> COND[irq_ctl_pkg::BIT_EXPBCD])
    else $error("decimal fault not on bit 9");

  // condition vector; external lines merged, never stored here
  always_comb begin
    COND = intl_q;
    COND[irq_ctl_pkg::CH_HI:irq_ctl_pkg::CH_LO] = intl_q[7:0] | CH_INT_EXT;
    COND[irq_ctl_pkg::BIT_EXPBCD] = intl_q[irq_ctl_pkg::BIT_EXPBCD] | flt_q | bcd_q;
  end

  // external lines pass through a clear untouched
  // they are levels owned by the channel, so nothing here can drop them
  ext_keep_a: assert property (@(posedge MCLK) disable iff (!RSTN)
    do_clear && CH_INT_EXT != 8'h00 |=>
      (COND[irq_ctl_pkg::CH_HI:irq_ctl_pkg::CH_LO] & CH_INT_EXT) == CH_INT_EXT)
    else $error("external line cleared");

  // ==========================================================
  // global enable with one-instruction hold-off
  irq_ctl_pkg::gen_state_t ge_q, ge_d;
  always_comb begin
    ge_d = ge_q;
    case (ge_q)
      irq_ctl_pkg::GE_OFF: begin
        if (do_on) ge_d = irq_ctl_pkg::GE_HOLD;
      end
      irq_ctl_pkg::GE_HOLD: begin
        if (do_off) ge_d = irq_ctl_pkg::GE_OFF;
        else if (INSTR_VALID && !do_on) ge_d = irq_ctl_pkg::GE_ON;
      end
      irq_ctl_pkg::GE_ON: begin
        if (do_off) ge_d = irq_ctl_pkg::GE_OFF;
      end
      default: ge_d = irq_ctl_pkg::GE_OFF;
    endcase
  end
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      ge_q <= irq_ctl_pkg::GE_OFF;
    end else begin
      ge_q <= ge_d;
    end
  end
  assign GLOBAL_EN = ge_q == irq_ctl_pkg::GE_ON;
  assign IRQ_TAKE  = GLOBAL_EN && |(COND & mask_q);
  assign MASK      = mask_q;

  // enable waits one instruction, disable and gating act at once
  // a repeated enable keeps holding, so a stream of enables never opens the gate
  enable_delay_a: assert property (@(posedge MCLK) disable iff (!RSTN)
    do_on && !GLOBAL_EN |=> !GLOBAL_EN)
    else $error("enable took effect at once");
  enable_rise_a: assert property (@(posedge MCLK) disable iff (!RSTN)
    $rose(GLOBAL_EN) |-> $past(ge_q == irq_ctl_pkg::GE_HOLD && INSTR_VALID && !do_on))
    else $error("enable rose without one more instruction");
  enable_after_a: assert property (@(posedge MCLK) disable iff (!RSTN)
    ge_q == irq_ctl_pkg::GE_HOLD && INSTR_VALID && !do_on && !do_off |=> GLOBAL_EN)
    else $error("enable did not follow next instruction");
  off_stays_a: assert property (@(posedge MCLK) disable iff (!RSTN)
    !GLOBAL_EN && !do_on && ge_q != irq_ctl_pkg::GE_HOLD |=> !GLOBAL_EN)
    else $error("enable rose without an enable operation");
  disable_now_a: assert property (@(posedge MCLK) disable iff (!RSTN)
    do_off |=> !IRQ_TAKE)
    else $error("interrupt taken after disable");
  take_gate_a: assert property (@(posedge MCLK) disable iff (!RSTN)
    IRQ_TAKE |-> GLOBAL_EN && (COND & MASK) != 12'h000)
    else $error("ungated take");
  float_take_a: assert property (@(posedge MCLK) disable iff (!RSTN)
    flt_q && MASK[irq_ctl_pkg::BIT_EXPBCD] && GLOBAL_EN |-> IRQ_TAKE)
    else $error("float fault not taken");

  // ==========================================================
  // peer interrupt request
  logic peer_q, peer_d;
  always_comb begin
    peer_d = do_peer | (peer_q & ~PEER_ACK);
  end
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      peer_q <= 1'b0;
    end else begin
      peer_q <= peer_d;
    end
  end
  assign PEER_IRQ = peer_q;

  // request rises on the operation and holds until recognised
  // a new request in the cycle of recognition wins, so it is not lost
  peer_raise_a: assert property (@(posedge MCLK) disable iff (!RSTN)
    do_peer |=> PEER_IRQ)
    else $error("peer irq not raised");
  peer_quiet_a: assert property (@(posedge MCLK) disable iff (!RSTN)
    !PEER_IRQ && !do_peer |=> !PEER_IRQ)
    else $error("peer irq rose on its own");
  peer_hold_a: assert property (@(posedge MCLK) disable iff (!RSTN)
    PEER_IRQ && !PEER_ACK |=> PEER_IRQ)
    else $error("peer irq dropped early");
  peer_drop_a: assert property (@(posedge MCLK) disable iff (!RSTN)
    PEER_IRQ && PEER_ACK && !do_peer |=> !PEER_IRQ)
    else $error("peer irq not released");

  // ==========================================================
  // status copy and sense result, registered
  logic [23:0] acc_q, acc_d;
  logic        ld_q, hit_q, hit_d;
  always_comb begin
    acc_d = acc_q;
    if (op_cpy) begin
      acc_d = 24'h000000;
      acc_d[irq_ctl_pkg::ACC_HI_LSB +: irq_ctl_pkg::MASK_W] = mask_q;
    end
    hit_d = op_sense && |(code & COND);
  end
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      acc_q <= 24'h000000;
      ld_q  <= 1'b0;
      hit_q <= 1'b0;
    end else begin
      acc_q <= acc_d;
      ld_q  <= op_cpy;
      hit_q <= hit_d;
    end
  end
  assign ACC_STATUS = acc_q;
  assign ACC_LOAD   = ld_q;
  assign SENSE_HIT  = hit_q;

  // status copy loads once and holds, sense result follows the compare
  copy_mask_a: assert property (@(posedge MCLK) disable iff (!RSTN)
    op_cpy |=> ACC_STATUS == {$past(mask_q), 12'h000} && ACC_LOAD)
    else $error("status copy wrong");
  copy_keep_a: assert property (@(posedge MCLK) disable iff (!RSTN)
    !op_cpy |=> !ACC_LOAD && $stable(ACC_STATUS))
    else $error("status changed without a copy");
  sense_hit_a: assert property (@(posedge MCLK) disable iff (!RSTN)
    op_sense |=> SENSE_HIT == ($past(code & COND) != 12'h000))
    else $error("sense result wrong");
  hit_quiet_a: assert property (@(posedge MCLK) disable iff (!RSTN)
    !op_sense |=> !SENSE_HIT)
    else $error("sense result without a sense");
endmodule // irq_ctl
`default_nettype wire

// File: bench/peer_model.sv
// associated processor model: recognizes the peer interrupt after a delay
`default_nettype none
module peer_model (
  input  wire logic       clk,    // processor clock
  input  wire logic       rstn,   // async reset, active low
  input  wire logic       irq,    // interrupt from the block
  input  wire logic [3:0] delay,  // cycles before recognition
  output logic            ack     // recognition pulse
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] wait_q;
  // count cycles of held request, then answer with one pulse
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wait_q <= 4'h0;
      ack    <= 1'b0;
    end else begin
      ack    <= irq && !ack && (wait_q >= delay);
      wait_q <= (irq && !ack) ? wait_q + 4'h1 : 4'h0;
    end
  end
endmodule // peer_model
`default_nettype wire

// File: bench/tb_top.sv
// self-checking bench for the interrupt control block
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic                mclk, rstn, valid, ack, clk_ev, ar_ev, ex_ev, bl_ev;
  logic                acc_load, hit, take, gen, pirq;
  irq_ctl_pkg::instr_t instr;
  logic [7:0]          ch_int, ch_ext;
  logic [11:0]         mask, cond;
  logic [23:0]         acc;
  logic [3:0]          delay;
  int                  mismatches, tests_run, cycles, n;
  irq_ctl i_irq_ctl (.MCLK(mclk), .RSTN(rstn), .INSTR(instr), .INSTR_VALID(valid),
    .CH_INT_INT(ch_int), .CH_INT_EXT(ch_ext), .CLOCK_EV(clk_ev), .ARITH_EV(ar_ev),
    .EXP_EV(ex_ev), .BLOCK_EV(bl_ev), .PEER_ACK(ack), .MASK(mask), .COND(cond),
    .ACC_STATUS(acc), .ACC_LOAD(acc_load), .SENSE_HIT(hit), .IRQ_TAKE(take),
    .GLOBAL_EN(gen), .PEER_IRQ(pirq));
  peer_model i_peer_model (.clk(mclk), .rstn(rstn), .irq(pirq), .delay(delay), .ack(ack));
  // ======== helpers
  task automatic chk(string what, logic [23:0] exp, logic [23:0] got);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  // execute one instruction of the control group
  task automatic op(logic [2:0] sub, logic [2:0] fn, logic [11:0] code);
    @(posedge mclk);
    #1 instr = '{irq_ctl_pkg::OP_MAJOR, sub, fn, code};
    valid = 1'b1;
    @(posedge mclk);
    #1 valid = 1'b0;
  endtask
  // one-cycle event pulses {block, arith, exp, clock} and channel events
  task automatic pulse_ev(logic [3:0] ev, logic [7:0] ch);
    @(posedge mclk);
    #1 {bl_ev, ar_ev, ex_ev, clk_ev} = ev;
    ch_int = ch;
    @(posedge mclk);
    #1 {bl_ev, ar_ev, ex_ev, clk_ev} = 4'h0;
    ch_int = 8'h00;
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // ======== scenarios
  task automatic t_mask();
    chk("mask rst", 24'(irq_ctl_pkg::MASK_RST), 24'(mask));
    op(irq_ctl_pkg::SUB_CTL5, irq_ctl_pkg::F5_MSET, 12'h0F0);
    op(irq_ctl_pkg::SUB_CTL5, irq_ctl_pkg::F5_MSET, 12'h801);
    chk("mask set", 24'h8F1, 24'(mask));
    op(irq_ctl_pkg::SUB_CTL5, irq_ctl_pkg::F5_MCLR, 12'h0A1);
    chk("mask clr", 24'h850, 24'(mask));
    op(irq_ctl_pkg::SUB_CPYI, 3'h0, 12'h000);
    chk("copy i", 24'h850000, acc);
    chk("load", 24'h1, 24'(acc_load));
    op(irq_ctl_pkg::SUB_CTL5, irq_ctl_pkg::F5_MCLR, 12'h050);
    op(irq_ctl_pkg::SUB_CPYX, 3'h0, 12'h000);
    chk("copy x", 24'h800000, acc);
  endtask
  task automatic t_faults();
    ch_ext = 8'h08;
    pulse_ev(4'h0, 8'h81);
    chk("cond ch", 24'h089, 24'(cond));
    op(irq_ctl_pkg::SUB_CTL5, irq_ctl_pkg::F5_CLEAR, 12'h0FF);
    chk("cond clr", 24'h008, 24'(cond));
    op(irq_ctl_pkg::SUB_CTL7, irq_ctl_pkg::F7_FLOAT, 12'h000);
    chk("float", 24'h208, 24'(cond));
    op(irq_ctl_pkg::SUB_CTL5, irq_ctl_pkg::F5_CLEAR, 12'h200);
    chk("float clr", 24'h008, 24'(cond));
    op(irq_ctl_pkg::SUB_CTL7, irq_ctl_pkg::F7_DEC, 12'h000);
    chk("decimal", 24'h208, 24'(cond));
    ch_ext = 8'h00;
  endtask
  task automatic t_enable();
    op(irq_ctl_pkg::SUB_CTL5, irq_ctl_pkg::F5_MSET, 12'h200);
    chk("take off", 24'h0, 24'(take));
    op(irq_ctl_pkg::SUB_CTL7, irq_ctl_pkg::F7_ON, 12'h000);
    chk("en hold", 24'h0, 24'(take));
    op(irq_ctl_pkg::SUB_CTL5, irq_ctl_pkg::F5_MSET, 12'h000);
    chk("en on", 24'h1, 24'(gen));
    chk("take on", 24'h1, 24'(take));
    op(irq_ctl_pkg::SUB_CTL5, irq_ctl_pkg::F5_MCLR, 12'h200);
    chk("take mask", 24'h0, 24'(take));
    op(irq_ctl_pkg::SUB_CTL5, irq_ctl_pkg::F5_MSET, 12'h200);
    op(irq_ctl_pkg::SUB_CTL7, irq_ctl_pkg::F7_OFF, 12'h000);
    chk("take dis", 24'h0, 24'(take));
  endtask
  task automatic t_sense();
    op(irq_ctl_pkg::SUB_CTL5, irq_ctl_pkg::F5_CLEAR, 12'h200);
    pulse_ev(4'hF, 8'h00);
    chk("cond ev", 24'hF00, 24'(cond));
    op(irq_ctl_pkg::SUB_SENSE, 3'h0, 12'h100);
    chk("hit", 24'h1, 24'(hit));
    chk("sensed", 24'hE00, 24'(cond));
    op(irq_ctl_pkg::SUB_SENSE, 3'h0, 12'h100);
    chk("no hit", 24'h0, 24'(hit));
  endtask
  task automatic t_reset();
    op(irq_ctl_pkg::SUB_CTL5, irq_ctl_pkg::F5_MSET, 12'hFFF);
    op(irq_ctl_pkg::SUB_CTL7, irq_ctl_pkg::F7_ON, 12'h000);
    op(irq_ctl_pkg::SUB_CPYX, 3'h0, 12'h000);
    chk("pre rst take", 24'h1, 24'(take));
    rstn = 1'b0;
    #1 chk("rst mask", 24'(irq_ctl_pkg::MASK_RST), 24'(mask));
    chk("rst cond", 24'h0, 24'(cond));
    chk("rst acc", 24'h0, acc);
    chk("rst en", 24'h0, 24'(gen));
    repeat (2) @(posedge mclk);
    #1 rstn = 1'b1;
    op(irq_ctl_pkg::SUB_CTL5, irq_ctl_pkg::F5_MSET, 12'h004);
    chk("rst first", 24'h004, 24'(mask));
    chk("rst still off", 24'h0, 24'(gen));
  endtask
  task automatic t_peer(logic [3:0] d);
    delay = d;
    op(irq_ctl_pkg::SUB_CTL5, irq_ctl_pkg::F5_PEER, 12'h000);
    for (n = 0; ack !== 1'b1 && n < 20; n++) begin
      chk("peer held", 24'h1, 24'(pirq));
      @(posedge mclk);
      #1;
    end
    @(posedge mclk);
    #1 chk("peer drop", 24'h0, 24'(pirq));
  endtask
  // ======== clock, watchdog, main sequence
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 2000) begin
      mismatches++;
      conclude();
    end
  end
  initial begin
    {rstn, valid, clk_ev, ar_ev, ex_ev, bl_ev} = 6'h00;
    instr = '0;
    {ch_int, ch_ext, delay} = 20'h00000;
    repeat (10) @(posedge mclk);
    #1 rstn = 1'b1;
    t_mask();
    t_faults();
    t_enable();
    t_sense();
    t_reset();
    t_peer(4'h0);
    t_peer(4'h5);
    conclude();
  end
endmodule // tb_top
`default_nettype wire
